// >>> cic_io_cell.sv
// Configurable io_cell: three storage elements, pad paths and register port
//
// Contract
// R1 - Each element selectable flip-flop or latch
// R2 - One shared clock, separate clock enables
// R3 - Shared set/reset, four modes per element
// R4 - Output drive and controls individually invertible
// R5 - Unconfigured pads held high impedance
// R6 - Unconfigured: no pull-down, no keeper
// R7 - Early pull-up is one global mode input
// R8 - Input delivered direct, registered, or both
// R9 - Optional delay ahead of input element
// R10 - Pad data direct or from output element
// R11 - Pad enable direct or from element
// R12 - Keeper weakly drives pad to sensed level
// R13 - Configured pads offer pull-up or pull-down
// R14 - Settings in reloadable configuration storage
// R15 - Latch transparent while clock active, else hold
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

module cic_io_cell
    import cic_pkg::*;
(
    // System clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Register port
    input wire logic [cic_pkg::CIC_ADDR_W-1:0] reg_addr_in,
    input wire logic [cic_pkg::CIC_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [cic_pkg::CIC_DATA_W-1:0] reg_rdata_out,
    // Device-wide configuration mode
    input wire logic pullup_mode_in,
    // Fabric side controls
    input wire logic cell_clk_in,
    input wire logic shared_set_reset_in,
    input wire logic in_ce_in,
    input wire logic out_ce_in,
    input wire logic oe_ce_in,
    // Fabric side data
    input wire logic fab_out_in,
    input wire logic fab_oe_in,
    output logic fab_in_direct_out,
    output logic fab_in_reg_out,
    // Pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_out,
    output logic pad_pull_up_out,
    output logic pad_pull_dn_out,
    output logic pad_keep_oe_out,
    output logic pad_keep_out
);
    import cic_pkg::*;

    // ==========================================================
    // Configuration storage
    logic [CIC_CFG_W-1:0] cfg_reg;       // Cell settings
    logic [CIC_CFG_W-1:0] cfg_next;
    logic done_reg;                      // Configuration complete
    logic done_next;
    logic [CIC_DATA_W-1:0] rdata_reg;    // Read data, one cycle after strobe
    logic [CIC_DATA_W-1:0] rdata_next;

    // Address decode
    wire hit_cfg = (reg_addr_in == CIC_CFG_OFS);
    wire hit_ctrl = (reg_addr_in == CIC_CTRL_OFS);
    wire hit_stat = (reg_addr_in == CIC_STAT_OFS);
    wire wr_cfg = reg_wr_in && hit_cfg;
    wire wr_ctrl = reg_wr_in && hit_ctrl;

    // Settings may be rewritten at any time to reload the cell
    assign cfg_next = wr_cfg ? reg_wdata_in[CIC_CFG_W-1:0] : cfg_reg;       // [R14]
    assign done_next = wr_ctrl ? reg_wdata_in[CIC_CTRL_DONE] : done_reg;    // [R14]

    // Storage update
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_reg <= CIC_CFG_RST;
            done_reg <= CIC_DONE_RST;
        end else begin
            cfg_reg <= cfg_next;
            done_reg <= done_next;
        end
    end

    // ==========================================================
    // Field decode
    wire clk_inv = cfg_reg[CIC_CFG_CLK_INV];
    wire sr_inv = cfg_reg[CIC_CFG_SR_INV];
    wire out_inv = cfg_reg[CIC_CFG_OUT_INV];
    wire oe_inv = cfg_reg[CIC_CFG_OE_INV];
    wire in_dly_en = cfg_reg[CIC_CFG_IN_DLY];
    wire out_use_reg = cfg_reg[CIC_CFG_OUT_REG];
    wire oe_use_reg = cfg_reg[CIC_CFG_OE_REG];
    wire keeper_sel = cfg_reg[CIC_CFG_KEEPER];
    wire pull_up_sel = cfg_reg[CIC_CFG_PULL_UP];
    wire pull_dn_sel = cfg_reg[CIC_CFG_PULL_DN];
    wire in_comb_en = cfg_reg[CIC_CFG_IN_COMB];
    wire in_reg_en = cfg_reg[CIC_CFG_IN_REG];
    wire cic_sr_mode_e in_srm = cic_sr_mode_e'(cfg_reg[CIC_CFG_IN_SRM+:2]);
    wire cic_sr_mode_e out_srm = cic_sr_mode_e'(cfg_reg[CIC_CFG_OUT_SRM+:2]);
    wire cic_sr_mode_e oe_srm = cic_sr_mode_e'(cfg_reg[CIC_CFG_OE_SRM+:2]);

    // ==========================================================
    // Control polarity
    wire clk_lvl = cell_clk_in ^ clk_inv;                                   // [R4]
    wire sr_act = shared_set_reset_in ^ sr_inv;                             // [R4]
    wire in_ce = in_ce_in ^ cfg_reg[CIC_CFG_IN_CE_INV];                     // [R4]
    wire out_ce = out_ce_in ^ cfg_reg[CIC_CFG_OUT_CE_INV];                  // [R4]
    wire oe_ce = oe_ce_in ^ cfg_reg[CIC_CFG_OE_CE_INV];                     // [R4]
    wire oe_ctl = fab_oe_in ^ oe_inv;                                       // [R4]

    // Cell clock sampled to find its active edge
    logic clk_lvl_reg;
    wire clk_rise = clk_lvl && !clk_lvl_reg;

    // Previous clock level
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            clk_lvl_reg <= 1'b0;
        end else begin
            clk_lvl_reg <= clk_lvl;
        end
    end

    // ==========================================================
    // Input path
    logic pad_dly_reg;                   // Delay stage ahead of input element
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pad_dly_reg <= CIC_Q_RST;
        end else begin
            pad_dly_reg <= pad_in;
        end
    end

    // Delay stage is bypassable; it pushes capture past the data hold window
    wire in_d = in_dly_en ? pad_dly_reg : pad_in;                           // [R9]
    logic in_q;
    logic out_q;
    logic oe_q;

    // ==========================================================
    // Three storage elements on one clock and one set/reset
    cic_store_elem u_in_elem (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .clk_level_in(clk_lvl),
        .clk_rise_in(clk_rise),
        .ce_in(in_ce),
        .sr_in(sr_act),
        .latch_mode_in(cfg_reg[CIC_CFG_IN_LATCH]),
        .sr_mode_in(in_srm),
        .d_in(in_d),
        .q_out(in_q)
    );

    cic_store_elem u_out_elem (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .clk_level_in(clk_lvl),
        .clk_rise_in(clk_rise),
        .ce_in(out_ce),
        .sr_in(sr_act),
        .latch_mode_in(cfg_reg[CIC_CFG_OUT_LATCH]),
        .sr_mode_in(out_srm),
        .d_in(fab_out_in),
        .q_out(out_q)
    );

    cic_store_elem u_oe_elem (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .clk_level_in(clk_lvl),
        .clk_rise_in(clk_rise),
        .ce_in(oe_ce),
        .sr_in(sr_act),
        .latch_mode_in(cfg_reg[CIC_CFG_OE_LATCH]),
        .sr_mode_in(oe_srm),
        .d_in(oe_ctl),
        .q_out(oe_q)
    );

    // ==========================================================
    // Fabric-facing input, either or both paths at once
    assign fab_in_direct_out = in_comb_en && pad_in;                        // [R8]
    assign fab_in_reg_out = in_reg_en && in_q;                              // [R8]

    // ==========================================================
    // Output path
    wire out_sel = out_use_reg ? out_q : fab_out_in;                        // [R10]
    wire oe_sel = oe_use_reg ? oe_q : oe_ctl;                               // [R11]
    assign pad_out = out_sel ^ out_inv;                                     // [R4]

    // Driver stays off until configuration is complete
    assign pad_oe_out = done_reg && oe_sel;                                 // [R5]

    // ==========================================================
    // Pulls and keeper
    wire pull_dn_cfg = pull_dn_sel && !pull_up_sel;                         // Pull-up wins a clash
    wire keep_cfg = keeper_sel && !pull_up_sel && !pull_dn_sel;
    // Early pull-up is one device-wide choice, not per pad
    assign pad_pull_up_out = done_reg ? pull_up_sel : pullup_mode_in;       // [R6] [R7] [R13]
    assign pad_pull_dn_out = done_reg && pull_dn_cfg;                       // [R6] [R13]
    // Keeper weakly follows the sensed level, holding it when all drivers stop
    assign pad_keep_oe_out = done_reg && keep_cfg && !pad_oe_out;           // [R6] [R12]
    assign pad_keep_out = pad_in;                                           // [R12]

    // ==========================================================
    // Read path
    wire [CIC_DATA_W-1:0] cfg_word = {{(CIC_DATA_W-CIC_CFG_W){1'b0}}, cfg_reg};
    wire [CIC_DATA_W-1:0] ctrl_word = {{(CIC_DATA_W-1){1'b0}}, done_reg};
    wire [CIC_DATA_W-1:0] stat_word = {{(CIC_DATA_W-5){1'b0}}, oe_q, out_q, in_q, pad_in, done_reg};

    // Select read word; unmapped addresses read zero
    always_comb begin
        if (!reg_rd_in) begin
            rdata_next = CIC_RD_ZERO;
        end else if (hit_cfg) begin
            rdata_next = cfg_word;
        end else if (hit_ctrl) begin
            rdata_next = ctrl_word;
        end else if (hit_stat) begin
            rdata_next = stat_word;
        end else begin
            rdata_next = CIC_RD_ZERO;
        end
    end

    // Read data register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_reg <= CIC_RD_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_out = rdata_reg;

endmodule : cic_io_cell

// >>> cic_pkg.sv
// Constants and types shared by the configurable io_cell design
package cic_pkg;

    // ==========================================================
    // Register bus geometry
    localparam int CIC_ADDR_W = 8;
    localparam int CIC_DATA_W = 32;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] CIC_CFG_OFS = 8'h00;    // Cell configuration word
    localparam logic [7:0] CIC_CTRL_OFS = 8'h04;   // Configuration done control
    localparam logic [7:0] CIC_STAT_OFS = 8'h08;   // Live cell state, read only

    // ==========================================================
    // Configuration word field positions
    localparam int CIC_CFG_IN_LATCH = 0;      // Input element is a latch
    localparam int CIC_CFG_OUT_LATCH = 1;     // Output element is a latch
    localparam int CIC_CFG_OE_LATCH = 2;      // Enable element is a latch
    localparam int CIC_CFG_IN_SRM = 3;        // Input set/reset mode, 2 bits
    localparam int CIC_CFG_OUT_SRM = 5;       // Output set/reset mode, 2 bits
    localparam int CIC_CFG_OE_SRM = 7;        // Enable set/reset mode, 2 bits
    localparam int CIC_CFG_CLK_INV = 9;       // Invert cell clock
    localparam int CIC_CFG_SR_INV = 10;       // Invert shared set/reset
    localparam int CIC_CFG_IN_CE_INV = 11;    // Invert input clock enable
    localparam int CIC_CFG_OUT_CE_INV = 12;   // Invert output clock enable
    localparam int CIC_CFG_OE_CE_INV = 13;    // Invert enable clock enable
    localparam int CIC_CFG_OUT_INV = 14;      // Invert pad output data
    localparam int CIC_CFG_IN_DLY = 15;       // Insert input delay stage
    localparam int CIC_CFG_OUT_REG = 16;      // Pad data from output element
    localparam int CIC_CFG_OE_REG = 17;       // Pad enable from enable element
    localparam int CIC_CFG_KEEPER = 18;       // Weak keeper selected
    localparam int CIC_CFG_PULL_UP = 19;      // Pull-up selected
    localparam int CIC_CFG_PULL_DN = 20;      // Pull-down selected
    localparam int CIC_CFG_IN_COMB = 21;      // Direct input path enabled
    localparam int CIC_CFG_IN_REG = 22;       // Registered input path enabled
    localparam int CIC_CFG_OE_INV = 23;       // Invert output enable control
    localparam int CIC_CFG_W = 24;            // Implemented width

    // ==========================================================
    // Control and status field positions
    localparam int CIC_CTRL_DONE = 0;         // Configuration complete
    localparam int CIC_STAT_DONE = 0;         // Mirror of done
    localparam int CIC_STAT_PAD = 1;          // Sensed pad level
    localparam int CIC_STAT_IN_Q = 2;         // Input element value
    localparam int CIC_STAT_OUT_Q = 3;        // Output element value
    localparam int CIC_STAT_OE_Q = 4;         // Enable element value

    // ==========================================================
    // Reset values
    localparam logic [CIC_CFG_W-1:0] CIC_CFG_RST = 24'h000000;
    localparam logic CIC_DONE_RST = 1'b0;
    localparam logic CIC_Q_RST = 1'b0;
    localparam logic [CIC_DATA_W-1:0] CIC_RD_ZERO = 32'h00000000;

    // ==========================================================
    // Set/reset behaviour of one storage element
    typedef enum logic [1:0] {
        CIC_SR_SYNC_SET,
        CIC_SR_SYNC_RESET,
        CIC_SR_ASYNC_PRESET,
        CIC_SR_ASYNC_CLEAR
    } cic_sr_mode_e;

endpackage : cic_pkg

// >>> cic_store_elem.sv
// One io_cell storage element: flip-flop or latch with set/reset options
`timescale 1ns/1ps

module cic_store_elem
    import cic_pkg::*;
(
    // System clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Polarity-adjusted controls
    input wire logic clk_level_in,
    input wire logic clk_rise_in,
    input wire logic ce_in,
    input wire logic sr_in,
    // Element configuration
    input wire logic latch_mode_in,
    input wire cic_pkg::cic_sr_mode_e sr_mode_in,
    // Data
    input wire logic d_in,
    output logic q_out
);
    import cic_pkg::*;

    // ==========================================================
    // Decode
    logic q_reg;         // Held value
    logic q_next;        // Next held value
    wire sr_is_async = (sr_mode_in == CIC_SR_ASYNC_PRESET) || (sr_mode_in == CIC_SR_ASYNC_CLEAR);
    wire sr_value = (sr_mode_in == CIC_SR_SYNC_SET) || (sr_mode_in == CIC_SR_ASYNC_PRESET);
    wire sr_force = sr_in && sr_is_async;                  // Immediate force [R3]
    wire transparent = latch_mode_in && clk_level_in && ce_in;  // Latch open [R15]
    wire edge_take = !latch_mode_in && clk_rise_in && ce_in;    // Flip-flop edge [R1] [R2]
    wire take = transparent || edge_take;
    wire take_data = sr_in ? sr_value : d_in;              // Synchronous set/reset wins [R3]

    // ==========================================================
    // Next value
    always_comb begin
        if (sr_force) begin
            q_next = sr_value;                             // Preset or clear [R3]
        end else if (take) begin
            q_next = take_data;
        end else begin
            q_next = q_reg;                                // Hold while closed [R15]
        end
    end

    // Held state
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            q_reg <= CIC_Q_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    // Latch passes data straight through while open
    assign q_out = sr_force ? sr_value : (transparent ? take_data : q_reg);  // [R15]

endmodule : cic_store_elem

// >>> cic_io_cell_props.sv
// Port checker for the configurable io_cell
`timescale 1ns/1ps

module cic_io_cell_props
    import cic_pkg::*;
(
    // Clock, reset and register port
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [cic_pkg::CIC_ADDR_W-1:0] reg_addr_in,
    input wire logic [cic_pkg::CIC_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [cic_pkg::CIC_DATA_W-1:0] reg_rdata_out,
    // Mode and fabric side
    input wire logic pullup_mode_in,
    input wire logic fab_out_in,
    input wire logic fab_oe_in,
    input wire logic fab_in_direct_out,
    // Pad side
    input wire logic pad_in,
    input wire logic pad_out,
    input wire logic pad_oe_out,
    input wire logic pad_pull_up_out,
    input wire logic pad_pull_dn_out,
    input wire logic pad_keep_oe_out,
    input wire logic pad_keep_out
);
    // ==========
    // Shadow copies of the configuration state
    logic [CIC_CFG_W-1:0] cfg_reg; // Configuration word
    logic done_reg; // Configured flag
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_reg <= CIC_CFG_RST;
            done_reg <= CIC_DONE_RST;
        end else if (reg_wr_in && reg_addr_in == CIC_CFG_OFS) begin
            cfg_reg <= reg_wdata_in[CIC_CFG_W-1:0];
        end else if (reg_wr_in && reg_addr_in == CIC_CTRL_OFS) begin
            done_reg <= reg_wdata_in[CIC_CTRL_DONE];
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // ==========
    // Properties
    property p_rd_idle;
        !reg_rd_in |=> reg_rdata_out == CIC_RD_ZERO;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    property p_rd_done;
        reg_rd_in && reg_addr_in == CIC_STAT_OFS |=> reg_rdata_out[CIC_STAT_DONE] == $past(done_reg);
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("status done bit wrong");
    property p_hiz;
        !done_reg |-> !pad_oe_out;
    endproperty
    a_hiz: assert property (p_hiz) else $error("driver on before done");
    property p_no_dn;
        !done_reg |-> !pad_pull_dn_out && !pad_keep_oe_out;
    endproperty
    a_no_dn: assert property (p_no_dn) else $error("pull-down or keeper before done");
    property p_early_pu;
        !done_reg |-> pad_pull_up_out == pullup_mode_in;
    endproperty
    a_early_pu: assert property (p_early_pu) else $error("early pull-up wrong");
    property p_direct_in;
        fab_in_direct_out == (pad_in & cfg_reg[CIC_CFG_IN_COMB]);
    endproperty
    a_direct_in: assert property (p_direct_in) else $error("direct input wrong");
    property p_pad_data;
        !cfg_reg[CIC_CFG_OUT_REG] |-> pad_out == (fab_out_in ^ cfg_reg[CIC_CFG_OUT_INV]);
    endproperty
    a_pad_data: assert property (p_pad_data) else $error("direct pad data wrong");
    property p_oe_direct;
        done_reg && !cfg_reg[CIC_CFG_OE_REG] |-> pad_oe_out == (fab_oe_in ^ cfg_reg[CIC_CFG_OE_INV]);
    endproperty
    a_oe_direct: assert property (p_oe_direct) else $error("direct enable wrong");
    property p_keep;
        pad_keep_oe_out |-> pad_keep_out == pad_in && cfg_reg[CIC_CFG_KEEPER] && !pad_oe_out;
    endproperty
    a_keep: assert property (p_keep) else $error("keeper wrong");
    property p_pull;
        done_reg |-> {pad_pull_up_out, pad_pull_dn_out} ==
            {cfg_reg[CIC_CFG_PULL_UP], cfg_reg[CIC_CFG_PULL_DN] & !cfg_reg[CIC_CFG_PULL_UP]};
    endproperty
    a_pull: assert property (p_pull) else $error("pull selection wrong");
    // Main scenarios reached
    c_done: cover property ($rose(done_reg));
    c_keep: cover property (pad_keep_oe_out);
    c_stat: cover property (reg_rd_in && reg_addr_in == CIC_STAT_OFS);
endmodule : cic_io_cell_props

bind cic_io_cell cic_io_cell_props cic_io_cell_props_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .pullup_mode_in(pullup_mode_in), .fab_out_in(fab_out_in),
    .fab_oe_in(fab_oe_in), .fab_in_direct_out(fab_in_direct_out), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_out(pad_oe_out), .pad_pull_up_out(pad_pull_up_out), .pad_pull_dn_out(pad_pull_dn_out),
    .pad_keep_oe_out(pad_keep_oe_out), .pad_keep_out(pad_keep_out));

// >>> cic_pad_model.sv
// Board-side model of the signal on the cell's pad
`timescale 1ns/1ps

module cic_pad_model (
    // Clock for the floating pattern
    input wire logic clk_sys_in,
    // Cell drivers
    input wire logic pad_out_in,
    input wire logic pad_oe_in,
    input wire logic pull_up_in,
    input wire logic pull_dn_in,
    input wire logic keep_oe_in,
    input wire logic keep_in,
    // Board driver
    input wire logic ext_en_in,
    input wire logic ext_val_in,
    // Resolved level
    output logic pad_level_out
);
    logic float_reg; // Undriven line flips every cycle
    logic keep_reg; // Level the keeper last sensed
    initial float_reg = 1'b0;
    // Keeper answers a clock later, so the pad never loops on itself
    always @(posedge clk_sys_in) begin
        float_reg <= !float_reg;
        keep_reg <= keep_in;
    end
    // Strong drivers, then pulls, then keeper, else floating
    assign pad_level_out = pad_oe_in ? pad_out_in : ext_en_in ? ext_val_in : pull_up_in ? 1'b1 :
        pull_dn_in ? 1'b0 : keep_oe_in ? keep_reg : float_reg;
endmodule : cic_pad_model

// >>> test_configurable_io_cell.sv
// Self-checking bench for the configurable io_cell
`timescale 1ns/1ps

module test_configurable_io_cell;
    import cic_pkg::*;
    // ==========
    // Design inputs, outputs and bench state
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [CIC_ADDR_W-1:0] reg_addr_in = 8'h00;
    logic [CIC_DATA_W-1:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [CIC_DATA_W-1:0] reg_rdata_out;
    logic pullup_mode_in = 1'b0;
    logic cell_clk_in = 1'b0;
    logic shared_set_reset_in = 1'b0;
    logic in_ce_in = 1'b0;
    logic out_ce_in = 1'b0;
    logic oe_ce_in = 1'b0;
    logic fab_out_in = 1'b0;
    logic fab_oe_in = 1'b0;
    logic fab_in_direct_out, fab_in_reg_out, pad_in, pad_out, pad_oe_out;
    logic pad_pull_up_out, pad_pull_dn_out, pad_keep_oe_out, pad_keep_out;
    logic ext_en = 1'b1; // Board drives the pad
    logic ext_val = 1'b0; // Board drive level
    logic civ = 1'b0; // Idle level of the cell clock
    logic d; // Random data bit
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int exp_q = 0; // Model of the output element
    int cfg_m; // Model of the configuration word
    // ==========
    // Design, board model and clock
    cic_io_cell cic_io_cell_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .pullup_mode_in(pullup_mode_in), .cell_clk_in(cell_clk_in),
        .shared_set_reset_in(shared_set_reset_in), .in_ce_in(in_ce_in), .out_ce_in(out_ce_in),
        .oe_ce_in(oe_ce_in), .fab_out_in(fab_out_in), .fab_oe_in(fab_oe_in),
        .fab_in_direct_out(fab_in_direct_out), .fab_in_reg_out(fab_in_reg_out), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_out(pad_oe_out), .pad_pull_up_out(pad_pull_up_out),
        .pad_pull_dn_out(pad_pull_dn_out), .pad_keep_oe_out(pad_keep_oe_out), .pad_keep_out(pad_keep_out));
    cic_pad_model cic_pad_model_i (.clk_sys_in(clk_sys_in), .pad_out_in(pad_out), .pad_oe_in(pad_oe_out),
        .pull_up_in(pad_pull_up_out), .pull_dn_in(pad_pull_dn_out), .keep_oe_in(pad_keep_oe_out),
        .keep_in(pad_keep_out), .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_level_out(pad_in));
    initial forever #12.5 clk_sys_in = !clk_sys_in;
    // Hang guard
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles > 3000) begin
            miscompares++;
            final_report();
        end
    end
    // ==========
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
    endtask : rdchk
    task automatic cfg_wr(input int c);
        cfg_m = c;
        wr(CIC_CFG_OFS, c);
        wr(CIC_CTRL_OFS, 32'h1);
    endtask : cfg_wr
    task automatic pulse();
        @(posedge clk_sys_in);
        cell_clk_in <= !civ;
        @(posedge clk_sys_in);
        cell_clk_in <= civ;
        @(posedge clk_sys_in);
        #1;
    endtask : pulse
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ==========
    // Main sequence
    initial begin
        void'($urandom(32'h6d97));
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rdchk(CIC_CTRL_OFS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            cfg_m = $urandom;
            wr(CIC_CFG_OFS, cfg_m);
            rdchk(CIC_CFG_OFS, cfg_m & 32'h00FFFFFF);
        end
        rdchk(8'h0C, 32'h0);
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys_in);
            pullup_mode_in <= p[0];
            fab_oe_in <= 1'b1;
            wr(CIC_CFG_OFS, 32'h1405F8);
            #1;
            chk({pad_oe_out, pad_pull_dn_out, pad_keep_oe_out, pad_pull_up_out}, p);
        end
        wr(CIC_CTRL_OFS, 32'h1);
        #1;
        chk({pad_oe_out, pad_pull_dn_out}, 3);
        $display("test preconfig done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys_in);
            civ = i[0];
            cell_clk_in <= civ;
            out_ce_in <= i[1];
            fab_oe_in <= 1'b0;
            fab_out_in <= exp_q[0];
            cfg_wr(32'h10000 | i[0] << 9 | i[1] << 12);
            @(posedge clk_sys_in);
            d = 1'($urandom);
            fab_out_in <= d;
            out_ce_in <= i[1] ^ !i[2];
            pulse();
            if (!i[2]) exp_q = d;
            chk(32'(pad_out), exp_q);
        end
        $display("test capture done");
        civ = 1'b0;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys_in);
            cell_clk_in <= 1'b0;
            out_ce_in <= 1'b1;
            shared_set_reset_in <= m[0];
            fab_out_in <= !(m == 0 || m == 2);
            cfg_wr(32'h10000 | m << 5 | m[0] << 10);
            pulse();
            chk(32'(pad_out), !(m == 0 || m == 2));
            @(posedge clk_sys_in);
            shared_set_reset_in <= !m[0];
            #1;
            chk(32'(pad_out), m[1] ? !m[0] : m[0]);
            pulse();
            chk(32'(pad_out), (m == 0 || m == 2));
        end
        $display("test set reset done");
        @(posedge clk_sys_in);
        shared_set_reset_in <= 1'b0;
        cfg_wr(32'h10002);
        d = 1'($urandom);
        @(posedge clk_sys_in);
        cell_clk_in <= 1'b1;
        fab_out_in <= d;
        @(posedge clk_sys_in);
        fab_out_in <= !d;
        #1;
        chk(32'(pad_out), !d);
        @(posedge clk_sys_in);
        cell_clk_in <= 1'b0;
        @(posedge clk_sys_in);
        fab_out_in <= d;
        #1;
        chk(32'(pad_out), !d);
        $display("test latch done");
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys_in);
            ext_val <= 1'b0;
            in_ce_in <= 1'b1;
            cfg_wr(32'h600000 | k << 15);
            @(posedge clk_sys_in);
            cell_clk_in <= 1'b1;
            ext_val <= 1'b1;
            @(posedge clk_sys_in);
            cell_clk_in <= 1'b0;
            @(posedge clk_sys_in);
            #1;
            chk({fab_in_reg_out, fab_in_direct_out}, {!k[0], 1'b1});
        end
        $display("test input done");
        for (int j = 0; j < 3; j++) begin
            @(posedge clk_sys_in);
            ext_en <= 1'b1;
            ext_val <= 1'($urandom);
            cfg_wr(32'h40000 << j);
            @(posedge clk_sys_in);
            ext_en <= 1'b0;
            repeat (3) @(posedge clk_sys_in);
            #1;
            chk(32'(pad_in), (j == 0) ? ext_val : (j == 1));
            rdchk(CIC_STAT_OFS, 32'h1 | 32'((j == 0) ? ext_val : (j == 1)) << 1 | 32'(d) << 3);
        end
        $display("test pad hold done");
        final_report();
    end
endmodule : test_configurable_io_cell
